// ### core/uart_host_pkg.sv
package uart_host_pkg;

    // System clock period, and the clock rate in kHz derived from it.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CLK_KHZ = 1000000000 / CLK_PERIOD_PS;

    // Internal reference that the bit rate is divided from, in kHz.
    localparam int REF_KHZ = 27120;

    // Phase accumulator that turns the system clock into reference ticks.
    localparam int ACC_W = 19; // Must hold the wrap value plus one step without overflow.
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

    // Rate divider register: exponent field, mantissa field, value after reset.
    localparam int EXP_MSB = 7;
    localparam int EXP_LSB = 5;
    localparam int MANT_MSB = 4;
    localparam int MANT_LSB = 0;
    localparam logic [7:0] DIV_RESET = 8'heb;
    localparam logic [12:0] MANT_LOW_ADD = 13'h001;
    localparam logic [12:0] MANT_HIGH_ADD = 13'h021;

    // Length of one bit, counted in reference ticks.
    localparam int BIT_LEN_W = 13;

    // Address at which the rate divider register answers on the link.
    localparam logic [5:0] DIV_ADDR = 6'h1f;

    // Address character layout.
    localparam int ADDR_DIR_BIT = 7;
    localparam int ADDR_MSB = 5;

    // Character layout: start, eight data bits, stop.
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'h9;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    typedef enum logic [2:0] {
        TXN_ADDR = 3'b001,
        TXN_WDATA = 3'b010,
        TXN_RFETCH = 3'b100
    } txn_state_t;

endpackage

// ### core/rate_if.sv
interface rate_if;
    import uart_host_pkg::*;

    logic [7:0] rate_setting;
    logic ref_tick;
    logic [BIT_LEN_W-1:0] bit_len;

    modport gen (
        input rate_setting,
        output ref_tick,
        output bit_len
    );

    modport use_side (
        output rate_setting,
        input ref_tick,
        input bit_len
    );
endinterface

// ### core/rate_gen.sv
module rate_gen
    import uart_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    rate_if.gen rate
);

    // RULE3 - exponent scaling factors
    // Bit length in reference ticks from exponent and mantissa.
    function automatic logic [BIT_LEN_W-1:0] divisor(input logic [7:0] setting);
        logic [2:0] rate_exponent;
        logic [BIT_LEN_W-1:0] rate_mantissa;
        rate_exponent = setting[EXP_MSB:EXP_LSB];
        rate_mantissa = BIT_LEN_W'(setting[MANT_MSB:MANT_LSB]);
        if (rate_exponent == 3'h0) begin
            divisor = rate_mantissa + MANT_LOW_ADD;
        end else begin
            divisor = (rate_mantissa + MANT_HIGH_ADD) << (rate_exponent - 3'h1);
        end
    endfunction

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_sum;

    assign acc_sum = acc_reg + ACC_STEP;

    // RULE6 - rate accuracy
    // Fractional accumulator: one tick per reference period on average.
    // The tick jitters by one system clock, far below the allowed rate error.
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_reg <= '0;
            rate.ref_tick <= 1'b0;
        end else if (acc_sum >= ACC_WRAP) begin
            acc_reg <= acc_sum - ACC_WRAP;
            rate.ref_tick <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            rate.ref_tick <= 1'b0;
        end
    end

    // RULE4 - divisor formula
    always_ff @(posedge clock) begin
        if (rst) begin
            rate.bit_len <= divisor(DIV_RESET);
        end else begin
            rate.bit_len <= divisor(rate.rate_setting);
        end
    end

endmodule

// ### core/uart_host_register_port.sv
// How it works
// RULE1 - After reset the link runs at 9.6 kbit/s until reprogrammed.
// RULE2 - Host sets rate by writing divider register: exponent and mantissa fields.
// RULE3 - Exponent 0..7 scales by 1,1,2,4,8,16,32,64; mantissa offset 1 or 33.
// RULE4 - Rate is reference/(m+1), or reference/(m+33)/2^(e-1) for nonzero exponent.
// RULE5 - Rates above 1228.8 kbit/s unsupported; host must not program them.
// RULE6 - Listed standard rates come within 1.5 percent of nominal.
// RULE7 - Character is start bit 0, eight data bits, stop bit 1.
// RULE8 - Address and data bits travel least significant bit first.
// RULE9 - No parity bit; stop follows the eighth data bit.
// RULE10 - Read: host sends address, device replies with register content.
// RULE11 - Write: address then data character, data stored in addressed register.
// RULE12 - Address bit 7 high means read, low means write.
// RULE13 - Address bit 6 reserved; bits 5 to 0 are register address.
// RULE14 - Exponent sits in divider bits 7 to 5, mantissa in 4 to 0.
module uart_host_register_port
    import uart_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic rx,
    output logic tx,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] serial_rate_divider,
    output logic frame_error
);

    rate_if rate ();

    rate_gen u_rate_gen (
        .clock(clock),
        .rst(rst),
        .rate(rate.gen)
    );

    // True when the tick ending the current count has arrived.
    function automatic logic count_done(input logic [BIT_LEN_W-1:0] cnt,
                                        input logic [BIT_LEN_W-1:0] len);
        count_done = (cnt + BIT_LEN_W'(1)) >= len;
    endfunction

    rx_state_t rx_state_reg;
    logic [BIT_LEN_W-1:0] rx_cnt_reg;
    logic [3:0] rx_bits_reg;
    logic [7:0] rx_shift_reg;
    logic rx_valid_reg;
    logic [BIT_LEN_W-1:0] half_len;

    txn_state_t txn_state_reg;
    logic [7:0] div_reg;
    logic [7:0] tx_data_reg;
    logic tx_load_reg;

    logic tx_busy_reg;
    logic [BIT_LEN_W-1:0] tx_cnt_reg;
    logic [3:0] tx_bits_reg;
    logic [8:0] tx_shift_reg;
    logic tx_reg;
    logic tx_wait_reg;

    // RULE14 - divider field layout
    assign rate.rate_setting = div_reg;
    assign half_len = rate.bit_len >> 1;

    // Receiver: finds the start edge, samples each bit at its middle.
    // RULE7 - receive character frame
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bits_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            frame_error <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            frame_error <= 1'b0;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!rx) begin
                        rx_state_reg <= RX_START;
                        rx_cnt_reg <= '0;
                    end
                end
                RX_START: begin
                    if (rate.ref_tick) begin
                        if (count_done(rx_cnt_reg, half_len)) begin
                            rx_cnt_reg <= '0;
                            rx_bits_reg <= 4'h0;
                            // A start that is gone by mid-bit was a glitch.
                            rx_state_reg <= rx ? RX_IDLE : RX_DATA;
                        end else begin
                            rx_cnt_reg <= rx_cnt_reg + BIT_LEN_W'(1);
                        end
                    end
                end
                RX_DATA: begin
                    if (rate.ref_tick) begin
                        if (count_done(rx_cnt_reg, rate.bit_len)) begin
                            rx_cnt_reg <= '0;
                            // RULE8 - LSB arrives first
                            rx_shift_reg <= {rx, rx_shift_reg[7:1]};
                            // RULE9 - stop follows bit eight
                            if (rx_bits_reg == DATA_LAST) begin
                                rx_state_reg <= RX_STOP;
                            end else begin
                                rx_bits_reg <= rx_bits_reg + 4'h1;
                            end
                        end else begin
                            rx_cnt_reg <= rx_cnt_reg + BIT_LEN_W'(1);
                        end
                    end
                end
                RX_STOP: begin
                    if (rate.ref_tick) begin
                        if (count_done(rx_cnt_reg, rate.bit_len)) begin
                            rx_cnt_reg <= '0;
                            rx_state_reg <= RX_IDLE;
                            // A low stop bit drops the character and flags it.
                            rx_valid_reg <= rx;
                            frame_error <= !rx;
                        end else begin
                            rx_cnt_reg <= rx_cnt_reg + BIT_LEN_W'(1);
                        end
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // Transaction sequencer: address character, then data or a reply.
    always_ff @(posedge clock) begin
        if (rst) begin
            txn_state_reg <= TXN_ADDR;
            reg_addr <= 6'h00;
            reg_wdata <= 8'h00;
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_load_reg <= 1'b0;
        end else begin
            reg_we <= 1'b0;
            tx_load_reg <= 1'b0;
            case (txn_state_reg)
                TXN_ADDR: begin
                    if (rx_valid_reg) begin
                        // RULE13 - six address bits
                        reg_addr <= rx_shift_reg[ADDR_MSB:0];
                        // RULE12 - direction bit
                        if (rx_shift_reg[ADDR_DIR_BIT]) begin
                            reg_re <= 1'b1;
                            txn_state_reg <= TXN_RFETCH;
                        end else begin
                            txn_state_reg <= TXN_WDATA;
                        end
                    end
                end
                TXN_WDATA: begin
                    // RULE11 - store write data
                    if (rx_valid_reg) begin
                        reg_wdata <= rx_shift_reg;
                        reg_we <= (reg_addr != DIV_ADDR);
                        txn_state_reg <= TXN_ADDR;
                    end
                end
                TXN_RFETCH: begin
                    // RULE10 - reply with content
                    // Waits for a reply still on the line to finish first.
                    if (!tx_busy_reg && !tx_load_reg) begin
                        reg_re <= 1'b0;
                        tx_data_reg <= (reg_addr == DIV_ADDR) ? div_reg : reg_rdata;
                        tx_load_reg <= 1'b1;
                        txn_state_reg <= TXN_ADDR;
                    end
                end
                default: begin
                    txn_state_reg <= TXN_ADDR;
                end
            endcase
        end
    end

    // RULE1 - default rate
    // RULE2 - host rewrites rate
    // RULE5 - rate limit unchecked
    // Settings faster than the limit are taken as written; avoiding them is the host's duty.
    // The new rate applies from the next character on.
    always_ff @(posedge clock) begin
        if (rst) begin
            div_reg <= DIV_RESET;
        end else if (txn_state_reg == TXN_WDATA && rx_valid_reg && reg_addr == DIV_ADDR) begin
            div_reg <= rx_shift_reg;
        end
    end

    assign serial_rate_divider = div_reg;

    // Transmitter: start bit, eight data bits LSB first, stop bit.
    // RULE7 - send character frame
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_bits_reg <= 4'h0;
            tx_shift_reg <= 9'h1ff;
            tx_reg <= 1'b1;
            tx_wait_reg <= 1'b0;
        end else if (!tx_busy_reg) begin
            if (tx_load_reg) begin
                tx_busy_reg <= 1'b1;
                tx_wait_reg <= 1'b1;
                tx_cnt_reg <= '0;
                tx_bits_reg <= 4'h0;
                // RULE9 - stop directly after data
                tx_shift_reg <= {1'b1, tx_data_reg};
            end
        end else if (rate.ref_tick) begin
            if (tx_wait_reg) begin
                // Opening the start bit on a tick keeps it a full bit long;
                // a load between ticks would otherwise shorten it by a tick.
                tx_wait_reg <= 1'b0;
                tx_reg <= 1'b0;
            end else if (count_done(tx_cnt_reg, rate.bit_len)) begin
                tx_cnt_reg <= '0;
                if (tx_bits_reg == FRAME_LAST) begin
                    tx_busy_reg <= 1'b0;
                    tx_reg <= 1'b1;
                end else begin
                    // RULE8 - LSB leaves first
                    tx_reg <= tx_shift_reg[0];
                    tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                    tx_bits_reg <= tx_bits_reg + 4'h1;
                end
            end else begin
                tx_cnt_reg <= tx_cnt_reg + BIT_LEN_W'(1);
            end
        end
    end

    assign tx = tx_reg;

endmodule

// ### sim/uart_port_properties.sv
module uart_port_checker
    import uart_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic rx,
    input wire logic tx,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] serial_rate_divider,
    input wire logic frame_error
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // After a fetch the reply start bit opens on the next reference tick.
    sequence fetch_s;
        ##[1:16] $fell(tx);
    endsequence

    // Even the fastest rate keeps a start bit low for many clocks.
    sequence start_s;
        !tx [*8];
    endsequence

    reset_vals_a: assert property (disable iff (1'b0) rst |=> tx && !reg_we
        && !reg_re && !frame_error && serial_rate_divider == DIV_RESET)
        else $error("outputs not at reset values");
    we_pulse_a: assert property (reg_we |=> !reg_we)
        else $error("write strobe longer than one cycle");
    we_div_a: assert property (reg_we |-> reg_addr != DIV_ADDR)
        else $error("write strobe for the divider address");
    err_pulse_a: assert property (frame_error |=> !frame_error)
        else $error("frame error longer than one cycle");
    fetch_len_a: assert property ($fell(reg_re) |-> fetch_s)
        else $error("reply did not follow the fetch");
    fetch_addr_a: assert property ($rose(reg_re) |=> $stable(reg_addr))
        else $error("address moved during fetch");
    start_hold_a: assert property ($fell(tx) |-> start_s)
        else $error("start bit too short");
    div_cause_a: assert property ($changed(serial_rate_divider) |-> reg_addr == DIV_ADDR)
        else $error("divider changed without a divider write");
    dir_excl_a: assert property (reg_we |-> !reg_re)
        else $error("write and read at once");
endmodule

bind uart_host_register_port uart_port_checker chk (.clock(clock), .rst(rst), .rx(rx),
    .tx(tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .serial_rate_divider(serial_rate_divider),
    .frame_error(frame_error));

// ### sim/host_serial_model.sv
module host_serial_model (
    input wire logic clock,
    output logic rx,
    input wire logic tx
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rx = 1'b1;

    // start low, LSB first, no parity.
    task automatic send(input logic [7:0] data, input int bit_clk, input logic stop);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx <= frame[i];
            // A low stop bit is cut short, so the line is high again before
            // the receiver could take the rest of it for a new start bit.
            repeat ((i == 9 && !stop) ? bit_clk * 3 / 4 : bit_clk) @(posedge clock);
        end
        if (!stop) begin
            rx <= 1'b1;
        end
    endtask

    // Bits are timed from the falling edge; the low run is counted on the way,
    // and equals the start bit only when the data LSB is one.
    task automatic receive(output logic [8:0] data, output int start_len, input int bit_clk);
        int n;
        logic low;
        n = 0;
        start_len = 0;
        low = 1'b1;
        while (tx !== 1'b0 && n < 400000) begin
            @(posedge clock);
            n++;
        end
        for (int k = 0; k < bit_clk + bit_clk / 2; k++) begin
            @(posedge clock);
            low = low && (tx === 1'b0);
            if (low) begin
                start_len++;
            end
        end
        for (int i = 0; i < 9; i++) begin
            data[i] = tx;
            repeat (bit_clk) @(posedge clock);
        end
    endtask
endmodule

// ### sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic rx, tx, reg_we, reg_re, frame_error;
    logic [5:0] reg_addr, we_addr;
    logic [7:0] reg_wdata, reg_rdata, serial_rate_divider, we_data;
    logic [8:0] reply;
    logic [7:0] rates [4] = '{8'h15, 8'h1c, 8'h3a, 8'h5a};
    logic [7:0] addrs [4] = '{8'h81, 8'hc3, 8'hbe, 8'h80};
    int bad_count = 0;
    int total_checks = 0;
    int bit_clk = 25958;
    int start_len, we_seen = 0, err_seen = 0, re_seen = 0;

    always #2 clock = ~clock;

    // External registers answer with their own address, so replies differ.
    assign reg_rdata = {reg_addr, 2'b01};

    uart_host_register_port uut (.clock(clock), .rst(rst), .rx(rx), .tx(tx),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .serial_rate_divider(serial_rate_divider),
        .frame_error(frame_error));
    host_serial_model host (.clock(clock), .rx(rx), .tx(tx));

    // Strobes last one cycle, so they are latched here as they pass.
    always @(posedge clock) begin
        if (reg_we === 1'b1) begin
            we_seen++;
            we_addr = reg_addr;
            we_data = reg_wdata;
        end
        if (frame_error === 1'b1) err_seen++;
        if (reg_re === 1'b1) re_seen++;
    end

    // Bit length in system clocks, rounded, from the divider fields.
    function automatic int clocks(input logic [7:0] d);
        int t;
        t = d[7:5] == 3'h0 ? d[4:0] + 1 : (d[4:0] + 33) << (d[7:5] - 1);
        return (t * 25000 + 1356) / 2712;
    endfunction

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bit edges may jitter by a clock against the rounded figure.
    task automatic check_len(input int got, input int exp);
        total_checks++;
        if (got < exp - 3 || got > exp + 3) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        host.send(addr, bit_clk, 1'b1);
        host.send(data, bit_clk, 1'b1);
        repeat (8) @(posedge clock);
    endtask

    task automatic read_reg(input logic [7:0] addr);
        fork
            host.send(addr, bit_clk, 1'b1);
            host.receive(reply, start_len, bit_clk);
        join
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The default rate costs about 520k clocks for the first write alone.
    initial begin
        #6000000;
        bad_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check_val(serial_rate_divider, 8'heb);
        check_val(tx, 1'b1);
        $display("test reset done");
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            write_reg(8'h1f, rates[i]);
            bit_clk = clocks(rates[i]);
            check_val(serial_rate_divider, rates[i]);
            read_reg(addrs[i]);
            check_val(reply, {1'b1, addrs[i][5:0], 2'b01});
            check_len(start_len, bit_clk);
            read_reg(8'h9f);
            check_val(reply, {1'b1, rates[i]});
            $display("test rate %h done", rates[i]);
        end
        check_val(re_seen, 8);
        write_reg(8'h05, 8'ha5);
        check_val({we_addr, we_data}, {6'h05, 8'ha5});
        write_reg(8'h6a, 8'h3c);
        check_val({we_addr, we_data}, {6'h2a, 8'h3c});
        check_val(we_seen, 2);
        $display("test writes done");
        host.send(8'h07, bit_clk, 1'b0);
        repeat (bit_clk) @(posedge clock);
        check_val(err_seen, 1);
        write_reg(8'h07, 8'h5a);
        check_val({we_addr, we_data}, {6'h07, 8'h5a});
        check_val(we_seen, 3);
        $display("test framing done");
        summarize();
    end
endmodule
